// File: include/sarcc_pkg.sv
// Package for the SAR converter control block: register map, fields, state and timing
package sarcc_pkg;

    // Byte offsets, one aligned word each
    localparam logic [5:0] SARCC_OFS_SC1 = 6'h00;
    localparam logic [5:0] SARCC_OFS_SC2 = 6'h04;
    localparam logic [5:0] SARCC_OFS_RESH = 6'h08;
    localparam logic [5:0] SARCC_OFS_RESL = 6'h0C;
    localparam logic [5:0] SARCC_OFS_CVH = 6'h10;
    localparam logic [5:0] SARCC_OFS_CVL = 6'h14;
    localparam logic [5:0] SARCC_OFS_CFG = 6'h18;
    localparam logic [5:0] SARCC_OFS_PIN_LOW = 6'h1C;
    localparam logic [5:0] SARCC_OFS_PIN_MID = 6'h20;
    localparam logic [5:0] SARCC_OFS_PIN_HIGH = 6'h24;

    // Status and control one fields
    localparam int SARCC_SC1_DONE_BIT = 7;
    localparam int SARCC_SC1_IRQ_EN_BIT = 6;
    localparam int SARCC_SC1_CONT_BIT = 5;
    // Status and control two fields
    localparam int SARCC_SC2_ACTIVE_BIT = 7;
    localparam int SARCC_SC2_HWT_EN_BIT = 6;
    localparam int SARCC_SC2_CMP_EN_BIT = 5;
    localparam int SARCC_SC2_CMP_GT_BIT = 4;
    // Configuration fields
    localparam int SARCC_CFG_LPC_BIT = 7;
    localparam int SARCC_CFG_DIV_LSB = 5;
    localparam int SARCC_CFG_LSMP_BIT = 4;
    localparam int SARCC_CFG_MODE_LSB = 2;
    localparam int SARCC_CFG_CLK_LSB = 0;

    // Reset values
    localparam logic [4:0] SARCC_CHAN_OFF = 5'h1F;
    localparam logic [7:0] SARCC_CFG_RESET = 8'h00;

    // Field encodings
    localparam logic [1:0] SARCC_MODE_8BIT = 2'h0;
    localparam logic [1:0] SARCC_MODE_10BIT = 2'h2;
    localparam logic [1:0] SARCC_CLK_BUS = 2'h0;
    localparam logic [1:0] SARCC_CLK_BUS_DIV2 = 2'h1;
    localparam logic [1:0] SARCC_CLK_ALT = 2'h2;
    localparam logic [1:0] SARCC_CLK_ASYNC = 2'h3;

    // Sample lengths in converter clock cycles
    localparam logic [5:0] SARCC_SAMPLE_SHORT = 6'h04;
    localparam logic [5:0] SARCC_SAMPLE_LONG = 6'h18;
    // Bus clocks a trial code is held before its comparator answer is read
    localparam logic [5:0] SARCC_CMP_SETTLE = 6'h02;
    localparam int SARCC_APPROX_W = 11;

    typedef enum logic [1:0] {
        SARCC_ST_IDLE = 2'b00,
        SARCC_ST_SAMPLE = 2'b01,
        SARCC_ST_CONVERT = 2'b11,
        SARCC_ST_STORE = 2'b10
    } sarcc_state_t;

    typedef struct packed {
        logic irq_en;
        logic cont;
        logic [4:0] chan;
        logic done;
    } sarcc_sc1_t;

    typedef struct packed {
        logic hwt_en;
        logic cmp_en;
        logic cmp_gt;
    } sarcc_sc2_t;

    typedef struct packed {
        logic [2:0] trig;
        logic [2:0] alt;
        logic [2:0] async_clk;
        logic [1:0] cmp;
        logic [1:0] stop;
    } sarcc_sync_t;

    typedef struct packed {
        sarcc_sc1_t sc1;
        sarcc_sc2_t sc2;
        logic [7:0] cfg;
        logic [9:0] cv;
        logic [9:0] res;
        logic [23:0] pin;
        sarcc_state_t fsm;
        logic [5:0] smp_cnt;
        logic [3:0] bit_idx;
        logic [SARCC_APPROX_W-1:0] code;
        logic [2:0] div_cnt;
        logic half;
        sarcc_sync_t sync;
        logic dp_wr;
        logic [5:0] dp_addr;
        logic [31:0] rdata;
        logic ready;
        logic irq;
        logic async_req;
        logic [23:0] port_rd;
    } sarcc_regs_t;

endpackage

// File: src/sarcc_ctrl.sv
// SAR converter control: AHB-Lite registers, clock select/divide, triggers, SAR sequencing, pin control
module sarcc_ctrl
    import sarcc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock sources from outside this domain
    input wire logic alternate_clock,
    input wire logic internal_async_clock,
    output logic async_clock_request,
    // Power mode from the system
    input wire logic stop_mode,
    // Hardware trigger
    input wire logic hw_trigger_input,
    // Analog front end
    input wire logic comparator_high,
    output logic [10:0] dac_code,
    output logic sample_enable,
    output logic low_power_config,
    output logic [4:0] channel_select,
    // Conversion done request
    output logic conv_done_irq,
    // Port pins
    input wire logic [23:0] port_pin_in,
    output logic [23:0] port_read_data,
    output logic [23:0] pin_output_hiz,
    output logic [23:0] pin_input_off,
    output logic [23:0] pin_pullup_off
);

    sarcc_regs_t s_reg;
    sarcc_regs_t s_next;

    // Decoded configuration
    logic [1:0] mode;
    logic [1:0] clk_sel;
    logic [1:0] div_sel;
    logic is_10bit;
    logic disabled;
    logic busy;
    logic src_tick;
    logic converter_clock_tick;
    logic [2:0] div_last;
    logic trig_edge;
    logic addr_phase;
    logic wr_any;
    logic wr_sc1;
    logic cfg_write;
    logic sw_start;
    logic hw_start;
    logic start;
    logic abort;
    logic [3:0] last_idx;
    logic [9:0] rounded;
    logic [10:0] cmp_diff;
    logic cmp_true;
    logic [7:0] wbyte;

    assign mode = s_reg.cfg[SARCC_CFG_MODE_LSB +: 2];
    assign clk_sel = s_reg.cfg[SARCC_CFG_CLK_LSB +: 2];
    assign div_sel = s_reg.cfg[SARCC_CFG_DIV_LSB +: 2];
    // Reserved mode codes fall back to 8-bit
    assign is_10bit = (mode == SARCC_MODE_10BIT);
    assign disabled = (s_reg.sc1.chan == SARCC_CHAN_OFF);
    assign busy = (s_reg.fsm != SARCC_ST_IDLE);

    // Source tick, then divide by 1/2/4/8
    always_comb begin
        case (clk_sel)
            SARCC_CLK_BUS: src_tick = 1'b1;
            SARCC_CLK_BUS_DIV2: src_tick = s_reg.half;
            SARCC_CLK_ALT: src_tick = s_reg.sync.alt[1] & ~s_reg.sync.alt[2];
            SARCC_CLK_ASYNC: src_tick = s_reg.sync.async_clk[1] & ~s_reg.sync.async_clk[2];
            default: src_tick = 1'b0;
        endcase
    end
    assign div_last = 3'((1 << div_sel) - 1);
    assign converter_clock_tick = src_tick && (s_reg.div_cnt == div_last);

    // Trigger edge seen only after two synchroniser stages
    assign trig_edge = s_reg.sync.trig[1] & ~s_reg.sync.trig[2];

    // Bus write decode
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_any = s_reg.dp_wr;
    assign wbyte = hwdata[7:0];
    assign wr_sc1 = wr_any && (s_reg.dp_addr == SARCC_OFS_SC1);
    assign cfg_write = wr_any && ((s_reg.dp_addr == SARCC_OFS_SC2) || (s_reg.dp_addr == SARCC_OFS_CFG) ||
                                  (s_reg.dp_addr == SARCC_OFS_CVH) || (s_reg.dp_addr == SARCC_OFS_CVL));

    // Starts: software write, or hardware edge only while idle
    assign sw_start = wr_sc1 && !s_reg.sc2.hwt_en && (wbyte[4:0] != SARCC_CHAN_OFF);
    assign hw_start = s_reg.sc2.hwt_en && trig_edge && !busy && !disabled && !wr_any;
    assign start = sw_start || hw_start;
    // Stop aborts unless the internal clock keeps running
    assign abort = wr_sc1 || cfg_write || disabled || (s_reg.sync.stop[1] && clk_sel != SARCC_CLK_ASYNC);

    // Ten-bit mode resolves 11 bits, eight-bit mode 9 bits
    assign last_idx = is_10bit ? 4'h0 : 4'h2;

    // Round half up, saturating at full scale
    always_comb begin
        if (is_10bit) begin
            rounded = (&s_reg.code) ? 10'h3FF : 10'((s_reg.code + 11'h001) >> 1);
        end else begin
            rounded = (&s_reg.code[10:2]) ? 10'h0FF : {2'h0, 8'((s_reg.code[10:2] + 9'h001) >> 1)};
        end
    end

    // Result plus two's complement of compare value
    always_comb begin
        if (is_10bit) begin
            cmp_diff = {1'b0, rounded} - {1'b0, s_reg.cv};
        end else begin
            cmp_diff = {3'h0, rounded[7:0]} - {3'h0, s_reg.cv[7:0]};
        end
        cmp_true = s_reg.sc2.cmp_gt ? !cmp_diff[10] : cmp_diff[10];
    end

    always_comb begin
        s_next = s_reg;

        // Synchronisers
        s_next.sync.trig = {s_reg.sync.trig[1:0], hw_trigger_input};
        s_next.sync.alt = {s_reg.sync.alt[1:0], alternate_clock};
        s_next.sync.async_clk = {s_reg.sync.async_clk[1:0], internal_async_clock};
        s_next.sync.cmp = {s_reg.sync.cmp[0], comparator_high};
        s_next.sync.stop = {s_reg.sync.stop[0], stop_mode};

        // Clock prescale
        s_next.half = ~s_reg.half;
        if (src_tick) begin
            s_next.div_cnt = (s_reg.div_cnt >= div_last) ? 3'h0 : 3'(s_reg.div_cnt + 3'h1);
        end

        // Register writes in the data phase
        if (wr_any) begin
            case (s_reg.dp_addr)
                SARCC_OFS_SC1: begin
                    s_next.sc1.irq_en = wbyte[SARCC_SC1_IRQ_EN_BIT];
                    s_next.sc1.cont = wbyte[SARCC_SC1_CONT_BIT];
                    s_next.sc1.chan = wbyte[4:0];
                    s_next.sc1.done = 1'b0;
                end
                SARCC_OFS_SC2: begin
                    s_next.sc2.hwt_en = wbyte[SARCC_SC2_HWT_EN_BIT];
                    s_next.sc2.cmp_en = wbyte[SARCC_SC2_CMP_EN_BIT];
                    s_next.sc2.cmp_gt = wbyte[SARCC_SC2_CMP_GT_BIT];
                end
                SARCC_OFS_CVH: s_next.cv[9:8] = wbyte[1:0];
                SARCC_OFS_CVL: s_next.cv[7:0] = wbyte;
                SARCC_OFS_CFG: s_next.cfg = wbyte;
                SARCC_OFS_PIN_LOW: s_next.pin[7:0] = wbyte;
                SARCC_OFS_PIN_MID: s_next.pin[15:8] = wbyte;
                SARCC_OFS_PIN_HIGH: s_next.pin[23:16] = wbyte;
                default: s_next.pin = s_reg.pin;
            endcase
        end

        // Conversion sequencer
        if (abort && !start) begin
            s_next.fsm = SARCC_ST_IDLE;
        end else if (start) begin
            s_next.fsm = SARCC_ST_SAMPLE;
            s_next.smp_cnt = s_reg.cfg[SARCC_CFG_LSMP_BIT] ? SARCC_SAMPLE_LONG : SARCC_SAMPLE_SHORT;
            s_next.code = '0;
        end else begin
            case (s_reg.fsm)
                SARCC_ST_IDLE: begin
                    s_next.code = '0;
                end
                SARCC_ST_SAMPLE: begin
                    if (converter_clock_tick) begin
                        if (s_reg.smp_cnt == 6'h01) begin
                            s_next.fsm = SARCC_ST_CONVERT;
                            s_next.bit_idx = 4'hA;
                            s_next.code = 11'h400;
                            s_next.smp_cnt = SARCC_CMP_SETTLE;
                        end else begin
                            s_next.smp_cnt = 6'(s_reg.smp_cnt - 6'h01);
                        end
                    end
                end
                SARCC_ST_CONVERT: begin
                    // Comparator passes two sync flops, so each trial waits for it before deciding
                    if (s_reg.smp_cnt != 6'h00) begin
                        s_next.smp_cnt = 6'(s_reg.smp_cnt - 6'h01);
                    end else if (converter_clock_tick) begin
                        s_next.code[s_reg.bit_idx] = s_reg.sync.cmp[1];
                        if (s_reg.bit_idx == last_idx) begin
                            s_next.fsm = SARCC_ST_STORE;
                        end else begin
                            s_next.bit_idx = 4'(s_reg.bit_idx - 4'h1);
                            s_next.code[4'(s_reg.bit_idx - 4'h1)] = 1'b1;
                            s_next.smp_cnt = SARCC_CMP_SETTLE;
                        end
                    end
                end
                SARCC_ST_STORE: begin
                    if (!s_reg.sc2.cmp_en || cmp_true) begin
                        if (s_reg.sc2.cmp_en) begin
                            s_next.res = is_10bit ? cmp_diff[9:0] : {2'h0, cmp_diff[7:0]};
                        end else begin
                            s_next.res = rounded;
                        end
                        s_next.sc1.done = 1'b1;
                    end
                    if (s_reg.sc1.cont) begin
                        s_next.fsm = SARCC_ST_SAMPLE;
                        s_next.smp_cnt = s_reg.cfg[SARCC_CFG_LSMP_BIT] ? SARCC_SAMPLE_LONG : SARCC_SAMPLE_SHORT;
                        s_next.code = '0;
                    end else begin
                        s_next.fsm = SARCC_ST_IDLE;
                    end
                end
                default: s_next.fsm = SARCC_ST_IDLE;
            endcase
        end

        // Internal clock held on only while converting with it selected
        s_next.async_req = (s_next.fsm != SARCC_ST_IDLE) && (clk_sel == SARCC_CLK_ASYNC);
        s_next.irq = s_next.sc1.done && s_next.sc1.irq_en;

        // Pins handed to the converter read back as zero
        // Masked with the new pin bits so a pin never reads nonzero once handed over
        s_next.port_rd = port_pin_in & ~s_next.pin;

        // Address phase capture and read data for the next cycle
        s_next.ready = 1'b1;
        if (hready) begin
            s_next.dp_wr = addr_phase && hwrite;
            s_next.dp_addr = {haddr[5:2], 2'b00};
            if (haddr[31:6] != 26'h0) begin
                s_next.dp_addr = 6'h3C;
            end
        end
        s_next.rdata = '0;
        if (addr_phase && !hwrite && haddr[31:6] == 26'h0) begin
            case ({haddr[5:2], 2'b00})
                SARCC_OFS_SC1: s_next.rdata[7:0] = {s_reg.sc1.done, s_reg.sc1.irq_en, s_reg.sc1.cont, s_reg.sc1.chan};
                SARCC_OFS_SC2: s_next.rdata[7:0] = {busy, s_reg.sc2.hwt_en, s_reg.sc2.cmp_en, s_reg.sc2.cmp_gt, 4'h0};
                SARCC_OFS_RESH: s_next.rdata[1:0] = s_reg.res[9:8];
                SARCC_OFS_RESL: s_next.rdata[7:0] = s_reg.res[7:0];
                SARCC_OFS_CVH: s_next.rdata[1:0] = s_reg.cv[9:8];
                SARCC_OFS_CVL: s_next.rdata[7:0] = s_reg.cv[7:0];
                SARCC_OFS_CFG: s_next.rdata[7:0] = s_reg.cfg;
                SARCC_OFS_PIN_LOW: s_next.rdata[7:0] = s_reg.pin[7:0];
                SARCC_OFS_PIN_MID: s_next.rdata[7:0] = s_reg.pin[15:8];
                SARCC_OFS_PIN_HIGH: s_next.rdata[7:0] = s_reg.pin[23:16];
                default: s_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.sc1.chan <= SARCC_CHAN_OFF;
            s_reg.cfg <= SARCC_CFG_RESET;
            s_reg.fsm <= SARCC_ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs are flop bits of the state, except hresp tied to zero and sample_enable decoded from the state
    assign hrdata = s_reg.rdata;
    assign hreadyout = s_reg.ready;
    assign hresp = 1'b0;
    assign async_clock_request = s_reg.async_req;
    assign dac_code = s_reg.code;
    assign sample_enable = (s_reg.fsm == SARCC_ST_SAMPLE);
    assign low_power_config = s_reg.cfg[SARCC_CFG_LPC_BIT];
    assign channel_select = s_reg.sc1.chan;
    assign conv_done_irq = s_reg.irq;
    assign port_read_data = s_reg.port_rd;
    assign pin_output_hiz = s_reg.pin;
    assign pin_input_off = s_reg.pin;
    assign pin_pullup_off = s_reg.pin;

endmodule

// File: verif/sarcc_afe_model.sv
// Far-side model: analog comparator on a chosen input level and the shared port pins
module sarcc_afe_model (
    // Clock
    input wire logic hclk,
    // Analog side
    input wire logic [10:0] level,
    input wire logic [10:0] dac_code,
    output logic comparator_high,
    // Port pins
    input wire logic [23:0] pin_input_off,
    output logic [23:0] port_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [23:0] PIN_DRIVE = 24'hC3A55A;
    logic tog = 1'b0;

    always @(posedge hclk) tog <= ~tog;
    assign comparator_high = level >= dac_code;
    // Released pins float, so they toggle rather than hold a plausible level
    assign port_pin_in = (pin_input_off & {24{tog}}) | (~pin_input_off & PIN_DRIVE);
endmodule

// File: verif/sarcc_ctrl_props.sv
// Concurrent checks on the converter control block's ports
module sarcc_ctrl_props
    import sarcc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Converter and pins
    input wire logic sample_enable,
    input wire logic [4:0] channel_select,
    input wire logic [23:0] port_read_data,
    input wire logic [23:0] pin_output_hiz,
    input wire logic [23:0] pin_input_off,
    input wire logic [23:0] pin_pullup_off
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire bus_wr = hsel && hready && htrans[1] && hwrite;
    wire bus_rd = hsel && hready && htrans[1] && !hwrite;
    logic samp_q;
    logic [3:0] quiet_cnt;

    // Cycles since sampling ended; a bus write may legally restart, so it clears the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_q <= 1'b0;
            quiet_cnt <= 4'h0;
        end else begin
            samp_q <= sample_enable;
            if (bus_wr)
                quiet_cnt <= 4'h0;
            else if (samp_q && !sample_enable)
                quiet_cnt <= 4'h1;
            else if (quiet_cnt != 4'h0 && quiet_cnt != 4'hF)
                quiet_cnt <= quiet_cnt + 4'h1;
        end
    end

    sequence short_sample_s;
        sample_enable [*4];
    endsequence

    pin_mirror_a: assert property (pin_input_off == pin_output_hiz && pin_pullup_off == pin_output_hiz)
        else $error("pin control outputs disagree");
    port_mask_a: assert property ((port_read_data & pin_input_off) == 24'h000000)
        else $error("disabled pin reads nonzero");
    chan_off_a: assert property ((channel_select == SARCC_CHAN_OFF && $past(channel_select) == SARCC_CHAN_OFF)
        |-> !sample_enable) else $error("sampling with channel off");
    reset_state_a: assert property ($rose(hresetn) |-> pin_output_hiz == 24'h000000 && !sample_enable)
        else $error("bad state after reset");
    sample_min_a: assert property ($rose(sample_enable) |-> short_sample_s)
        else $error("sample window too short");
    busy_hold_a: assert property (quiet_cnt inside {[4'h1:4'h8]} |-> !sample_enable)
        else $error("restart during conversion");
    rdata_idle_a: assert property (!$past(bus_rd) |-> hrdata == 32'h00000000)
        else $error("read data outside data phase");
    upper_zero_a: assert property ($past(bus_rd) |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    bus_okay_a: assert property ($past(hresetn) |-> hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus not ready or error");
endmodule

bind sarcc_ctrl sarcc_ctrl_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .sample_enable, .channel_select, .port_read_data, .pin_output_hiz, .pin_input_off, .pin_pullup_off);

// File: verif/tb_top.sv
// Self-checking bench for the converter control block
module tb_top
    import sarcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0] cfg; logic [7:0] sc2; logic [7:0] sc1; logic [10:0] lvl; logic ten; logic stp; logic [9:0] res;
    } sarcc_row_t;
    // cfg/sc2/sc1, input level, 10-bit mode, stop during run, expected stored value
    sarcc_row_t rows [6] = '{'{8'h08, 8'h00, 8'h43, 11'h555, 1'b1, 1'b0, 10'h2AB},
        '{8'h29, 8'h00, 8'h03, 11'h7FF, 1'b1, 1'b0, 10'h3FF}, '{8'h5A, 8'h00, 8'h43, 11'h001, 1'b1, 1'b0, 10'h001},
        '{8'hF3, 8'h00, 8'h43, 11'h7FC, 1'b0, 1'b1, 10'h0FF}, '{8'h0C, 8'h00, 8'h43, 11'h000, 1'b0, 1'b0, 10'h000},
        '{8'h08, 8'h30, 8'h43, 11'h555, 1'b1, 1'b0, 10'h1AB}};

    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, alt_clk = 1'b0, int_clk = 1'b0;
    logic stop_mode = 1'b0, hw_trig = 1'b0, samp_q = 1'b0, comparator_high;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [10:0] level = 11'h000, dac_code;
    logic [23:0] port_pin_in, port_read_data, pin_output_hiz, pin_input_off, pin_pullup_off;
    logic hreadyout, hresp, async_clock_request, sample_enable, low_power_config, conv_done_irq;
    logic [4:0] channel_select;
    int n_fail = 0, num_checks = 0, n_starts = 0, k;

    always #2.5 hclk = ~hclk;
    always #15 alt_clk = ~alt_clk;
    always #20 int_clk = ~int_clk;
    always @(posedge hclk) begin
        n_starts += int'(sample_enable && !samp_q);
        samp_q = sample_enable;
    end

    sarcc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .alternate_clock(alt_clk), .internal_async_clock(int_clk),
        .async_clock_request(async_clock_request), .stop_mode(stop_mode), .hw_trigger_input(hw_trig),
        .comparator_high(comparator_high), .dac_code(dac_code), .sample_enable(sample_enable),
        .low_power_config(low_power_config), .channel_select(channel_select), .conv_done_irq(conv_done_irq),
        .port_pin_in(port_pin_in), .port_read_data(port_read_data), .pin_output_hiz(pin_output_hiz),
        .pin_input_off(pin_input_off), .pin_pullup_off(pin_pullup_off));
    sarcc_afe_model u_afe (.hclk(hclk), .level(level), .dac_code(dac_code), .comparator_high(comparator_high),
        .pin_input_off(pin_input_off), .port_pin_in(port_pin_in));

    task automatic stop_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic timeout(input string m);
        n_fail++;
        $display("CHECK FAILED at %0t: %s timed out", $time, m);
        stop_test();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            timeout("bus");
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rdv = hrdata;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdv, exp, "register read");
    endtask

    // Polls the done flag; reads never abort a conversion
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            bus(1'b0, SARCC_OFS_SC1, 8'h00);
            n++;
        end while (rdv[7] !== 1'b1 && n < 3000);
        if (n >= 3000)
            timeout("conversion");
    endtask

    task automatic pulse;
        @(posedge hclk);
        hw_trig <= 1'b1;
        repeat (4) @(posedge hclk);
        hw_trig <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(SARCC_OFS_SC1, 32'h1F);
        rchk(SARCC_OFS_CFG, 32'h00);
        rchk(SARCC_OFS_PIN_MID, 32'h00);
        bus(1'b1, 6'h28, 8'hFF);
        rchk(6'h28, 32'h00);
        bus(1'b1, SARCC_OFS_PIN_LOW, 8'h81);
        bus(1'b1, SARCC_OFS_PIN_MID, 8'hA5);
        bus(1'b1, SARCC_OFS_PIN_HIGH, 8'h3C);
        rchk(SARCC_OFS_PIN_MID, 32'hA5);
        rchk(SARCC_OFS_PIN_HIGH, 32'h3C);
        chk({8'h0, pin_output_hiz}, 32'h3CA581, "hiz");
        chk({8'h0, pin_pullup_off}, 32'h3CA581, "pullup");
        chk({8'h0, port_read_data}, {8'h0, 24'hC3A55A & ~24'h3CA581}, "port");
        bus(1'b1, SARCC_OFS_CVH, 8'h01);
        bus(1'b1, SARCC_OFS_CVL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, SARCC_OFS_SC2, rows[i].sc2);
            bus(1'b1, SARCC_OFS_CFG, rows[i].cfg);
            level <= rows[i].lvl;
            bus(1'b1, SARCC_OFS_SC1, rows[i].sc1);
            stop_mode <= rows[i].stp;
            @(posedge hclk);
            chk({31'h0, async_clock_request}, {31'h0, rows[i].cfg[1:0] == 2'h3}, "async request");
            wait_done();
            chk({21'h0, dac_code}, 32'h0, "idle code");
            chk(rdv, {24'h0, 1'b1, rows[i].sc1[6:0]}, "done flag");
            chk({31'h0, conv_done_irq}, {31'h0, rows[i].sc1[6]}, "irq");
            chk({31'h0, low_power_config}, {31'h0, rows[i].cfg[7]}, "low power");
            chk({27'h0, channel_select}, {27'h0, rows[i].sc1[4:0]}, "channel");
            rchk(SARCC_OFS_RESL, {24'h0, rows[i].res[7:0]});
            if (rows[i].ten)
                rchk(SARCC_OFS_RESH, {30'h0, rows[i].res[9:8]});
            stop_mode <= 1'b0;
        end
        bus(1'b1, SARCC_OFS_SC2, 8'h40);
        bus(1'b1, SARCC_OFS_CFG, 8'h18);
        level <= 11'h201;
        bus(1'b1, SARCC_OFS_SC1, 8'h43);
        k = n_starts;
        repeat (20) @(posedge hclk);
        chk(n_starts, k, "start without trigger");
        pulse();
        repeat (4) @(posedge hclk);
        pulse();
        wait_done();
        chk(n_starts, k + 1, "trigger starts");
        rchk(SARCC_OFS_RESL, 32'h01);
        bus(1'b1, SARCC_OFS_SC2, 8'h00);
        bus(1'b1, SARCC_OFS_SC1, 8'h5F);
        k = n_starts;
        repeat (60) @(posedge hclk);
        chk(n_starts, k, "channel off start");
        bus(1'b1, SARCC_OFS_CFG, 8'h08);
        bus(1'b1, SARCC_OFS_SC1, 8'h43);
        // Stop arrives during the trial bits, after the full sample window
        repeat (8) @(posedge hclk);
        stop_mode <= 1'b1;
        repeat (200) @(posedge hclk);
        rchk(SARCC_OFS_SC1, 32'h43);
        stop_mode <= 1'b0;
        stop_test();
    end
endmodule
